// ---- hw/mscm_bank.sv ----
// mscm_bank: status, clock monitor, link maintenance and address match bank
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module mscm_bank #(
  parameter int ADDR_W = 8,
  parameter int XADDR_W = 11
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // monitored clocks, sampled as levels
  input wire logic bus_input_clock,
  input wire logic bus_output_clock,
  input wire logic reference_clock_in,
  input wire logic hs_link_clock,
  input wire logic bus_interface_select,
  // source status
  input wire logic ref_unlocked_in,
  input wire logic [1:0] code_status_pending,
  input wire logic serial_rx_pending,
  input wire logic [1:0] extract_fifo_pending,
  // interrupt pin, open drain
  output logic irq_out_n,
  output logic irq_out_n_oe,
  // link datapath, index 0 is link 1
  input wire logic [1:0] link_los,
  input wire logic [1:0] link_lcd,
  input wire logic [1:0] remote_loop_req,
  input wire logic [1:0] link_tx_data,
  input wire logic [1:0] link_rx_sliced,
  input wire logic [1:0] link_rx_recovered,
  output logic link1_tx_pair,
  output logic link1_tx_pair_oe,
  output logic link2_tx_pair,
  output logic link2_tx_pair_oe,
  output logic [1:0] rx_clk_from_tx,
  output logic [1:0] rx_data_to_core,
  output logic [1:0] send_defect_code,
  // extended address match
  input wire logic in_port_bus_master_sel,
  input wire logic ext_addr_protocol_sel,
  input wire logic [XADDR_W-1:0] prepend_xaddr_in,
  input wire logic prepend_xaddr_valid,
  output logic cell_accept,
  input wire logic out_port_bus_master_sel,
  input wire logic out_bus8_sel,
  input wire logic [15:0] out_prepend_in,
  output logic [15:0] out_prepend_xaddr
);

  typedef struct packed {
    logic aw_hold;
    logic [ADDR_W-1:0] aw_addr;
    logic w_hold;
    logic [7:0] w_byte;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic master_irq_en;
    logic lock_irq_en;
    logic lock_chg;
    logic serial_rx;
    logic [2:0] activity;
    logic [7:0] maint;
    logic [XADDR_W-1:0] ext_addr_match_value;
    logic [XADDR_W-1:0] ext_addr_mask_value;
    logic [2:0] div_cnt;
    logic csd_clk;
    logic irq_n;
    logic irq_oe;
    logic [1:0] tx_pair;
    logic [1:0] tx_oe;
    logic [1:0] rx_clk_tx;
    logic [1:0] rx_data;
    logic [1:0] defect;
    logic accept;
    logic [15:0] out_xaddr;
  } mscm_state_t;

  mscm_state_t st_r;
  mscm_state_t st_nxt;

  logic in_rise;
  logic out_rise;
  logic ref_rise;
  logic hs_rise;
  logic csd_rise;
  logic lock_change;
  logic in_clk_sel;

  // ------------------------------------------------------------
  // edge detection on the sampled clocks
  // ------------------------------------------------------------
  assign in_clk_sel = bus_interface_select ? bus_input_clock : st_r.csd_clk;

  mscm_rise_detect u_in_clk (
    .aclk(aclk), .aresetn(aresetn), .level_in(in_clk_sel),
    .rise_pulse(in_rise), .change_pulse()
  );
  mscm_rise_detect u_out_clk (
    .aclk(aclk), .aresetn(aresetn), .level_in(bus_output_clock),
    .rise_pulse(out_rise), .change_pulse()
  );
  mscm_rise_detect u_ref_clk (
    .aclk(aclk), .aresetn(aresetn), .level_in(reference_clock_in),
    .rise_pulse(ref_rise), .change_pulse()
  );
  mscm_rise_detect u_hs_clk (
    .aclk(aclk), .aresetn(aresetn), .level_in(hs_link_clock),
    .rise_pulse(hs_rise), .change_pulse()
  );
  mscm_rise_detect u_lock (
    .aclk(aclk), .aresetn(aresetn), .level_in(ref_unlocked_in),
    .rise_pulse(), .change_pulse(lock_change)
  );

  assign csd_rise = hs_rise && !st_r.csd_clk &&
    (st_r.div_cnt == 3'((mscm_pkg::SERIAL_CLK_DIV / 2) - 1));

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] rd_idx;
    logic [7:0] wr_idx;
    logic [7:0] rd_val;
    logic rd_hit;
    logic do_read;
    logic do_write;
    logic rd_misc;
    logic rd_clk;
    logic [XADDR_W-1:0] diff;
    rd_idx = 8'(araddr >> 2);
    wr_idx = 8'(st_r.aw_addr >> 2);
    rd_val = 8'h00;
    rd_hit = 1'b1;
    diff = '0;
    do_read = 1'b0;
    do_write = 1'b0;
    rd_misc = 1'b0;
    rd_clk = 1'b0;
    st_nxt = st_r;

    // divider producing the internal serial clock, high-speed over six
    if (hs_rise) begin
      if (st_r.div_cnt == 3'((mscm_pkg::SERIAL_CLK_DIV / 2) - 1)) begin
        st_nxt.div_cnt = 3'h0;
        st_nxt.csd_clk = ~st_r.csd_clk;
      end else begin
        st_nxt.div_cnt = st_r.div_cnt + 3'h1;
      end
    end

    // register read: misc summary and clock monitor reads have side effects
    do_read = arvalid && st_r.arready;
    case (rd_idx)
      mscm_pkg::IDX_MASTER_CFG: begin
        rd_val[mscm_pkg::CFG_MASTER_IRQ_EN] = st_r.master_irq_en;
      end
      mscm_pkg::IDX_MISC_IRQ: begin
        rd_val[mscm_pkg::MISC_REF_LOCK_CHG] = st_r.lock_chg;
        rd_val[mscm_pkg::MISC_CODE_STATUS] = |code_status_pending;
        rd_val[mscm_pkg::MISC_SERIAL_RX] = st_r.serial_rx;
        rd_val[mscm_pkg::MISC_EXTRACT_FIFO] = |extract_fifo_pending;
      end
      mscm_pkg::IDX_CLK_MON: begin
        rd_val[2:0] = st_r.activity;
        rd_val[mscm_pkg::CLK_UNLOCKED] = ref_unlocked_in;
        rd_val[mscm_pkg::CLK_LOCK_IRQ_EN] = st_r.lock_irq_en;
      end
      mscm_pkg::IDX_LINK_MAINT: rd_val = st_r.maint;
      mscm_pkg::IDX_XAD_LOW: rd_val = st_r.ext_addr_match_value[7:0];
      mscm_pkg::IDX_XAD_HIGH: rd_val[2:0] = st_r.ext_addr_match_value[XADDR_W-1:8];
      mscm_pkg::IDX_XAM_LOW: rd_val = st_r.ext_addr_mask_value[7:0];
      mscm_pkg::IDX_XAM_HIGH: rd_val[2:0] = st_r.ext_addr_mask_value[XADDR_W-1:8];
      default: rd_hit = 1'b0;
    endcase
    rd_misc = do_read && (rd_idx == mscm_pkg::IDX_MISC_IRQ);
    rd_clk = do_read && (rd_idx == mscm_pkg::IDX_CLK_MON);
    if (do_read) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = {24'h000000, rd_val};
      st_nxt.rresp = rd_hit ? mscm_pkg::RESP_OKAY : mscm_pkg::RESP_SLVERR;
    end else if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.arready = !st_nxt.rvalid;

    // sticky flags: a new event in the clearing cycle wins
    if (rd_misc) begin
      st_nxt.lock_chg = 1'b0;
      st_nxt.serial_rx = 1'b0;
    end
    if (lock_change) st_nxt.lock_chg = 1'b1;
    if (serial_rx_pending) st_nxt.serial_rx = 1'b1;
    if (rd_clk) st_nxt.activity = 3'h0;
    if (in_rise && bus_interface_select) begin
      st_nxt.activity[mscm_pkg::CLK_IN_ACT] = 1'b1;
    end
    if (csd_rise && !bus_interface_select) begin
      st_nxt.activity[mscm_pkg::CLK_IN_ACT] = 1'b1;
    end
    if (out_rise) st_nxt.activity[mscm_pkg::CLK_OUT_ACT] = 1'b1;
    if (ref_rise) st_nxt.activity[mscm_pkg::CLK_REF_ACT] = 1'b1;

    // write channel: address and data taken in either order
    if (awvalid && st_r.awready) begin
      st_nxt.aw_hold = 1'b1;
      st_nxt.aw_addr = awaddr;
    end
    if (wvalid && st_r.wready) begin
      st_nxt.w_hold = 1'b1;
      st_nxt.w_byte = wdata[7:0];
      st_nxt.w_lane0 = wstrb[0];
    end
    do_write = st_r.aw_hold && st_r.w_hold && !st_r.bvalid;
    if (do_write) begin
      st_nxt.aw_hold = 1'b0;
      st_nxt.w_hold = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = mscm_pkg::RESP_OKAY;
      // only the low lane carries register bits; others are dropped
      case (wr_idx)
        mscm_pkg::IDX_MASTER_CFG: begin
          if (st_r.w_lane0) begin
            st_nxt.master_irq_en = st_r.w_byte[mscm_pkg::CFG_MASTER_IRQ_EN];
          end
        end
        mscm_pkg::IDX_MISC_IRQ: ;
        mscm_pkg::IDX_CLK_MON: begin
          if (st_r.w_lane0) begin
            st_nxt.lock_irq_en = st_r.w_byte[mscm_pkg::CLK_LOCK_IRQ_EN];
          end
        end
        mscm_pkg::IDX_LINK_MAINT: begin
          if (st_r.w_lane0) st_nxt.maint = st_r.w_byte;
        end
        mscm_pkg::IDX_XAD_LOW: begin
          if (st_r.w_lane0) st_nxt.ext_addr_match_value[7:0] = st_r.w_byte;
        end
        mscm_pkg::IDX_XAD_HIGH: begin
          if (st_r.w_lane0) begin
            st_nxt.ext_addr_match_value[XADDR_W-1:8] = st_r.w_byte[2:0];
          end
        end
        mscm_pkg::IDX_XAM_LOW: begin
          if (st_r.w_lane0) st_nxt.ext_addr_mask_value[7:0] = st_r.w_byte;
        end
        mscm_pkg::IDX_XAM_HIGH: begin
          if (st_r.w_lane0) st_nxt.ext_addr_mask_value[XADDR_W-1:8] = st_r.w_byte[2:0];
        end
        default: st_nxt.bresp = mscm_pkg::RESP_SLVERR;
      endcase
    end else if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    st_nxt.awready = !st_nxt.aw_hold && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_hold && !st_nxt.bvalid;

    // interrupt pin: pulled low while a lock change is pending and enabled
    st_nxt.irq_n = 1'b0;
    st_nxt.irq_oe = st_nxt.master_irq_en && st_nxt.lock_irq_en &&
      st_nxt.lock_chg;

    // link maintenance datapath
    for (int i = 0; i < 2; i++) begin
      st_nxt.rx_clk_tx[i] = st_nxt.maint[mscm_pkg::MAINT_DIAG_LOOP + i];
      st_nxt.rx_data[i] = st_nxt.rx_clk_tx[i] ? link_tx_data[i] :
        link_rx_recovered[i];
      st_nxt.tx_pair[i] = (st_nxt.maint[mscm_pkg::MAINT_METAL_LOOP + i] ||
        remote_loop_req[i]) ? link_rx_sliced[i] : link_tx_data[i];
      st_nxt.tx_oe[i] = !st_nxt.maint[mscm_pkg::MAINT_TX_FLOAT + i];
      st_nxt.defect[i] = !st_nxt.maint[mscm_pkg::MAINT_DEFECT_OFF + i] &&
        (link_los[i] || link_lcd[i]);
    end

    // extended address compare, positions with a clear mask bit always match
    diff = (prepend_xaddr_in ^ st_nxt.ext_addr_match_value) & st_nxt.ext_addr_mask_value;
    st_nxt.accept = prepend_xaddr_valid && ext_addr_protocol_sel &&
      !in_port_bus_master_sel && (diff == '0);

    // prepend insertion on the slave output port
    st_nxt.out_xaddr = out_prepend_in;
    if (!out_port_bus_master_sel) begin
      if (out_bus8_sel) begin
        st_nxt.out_xaddr[7:5] = st_nxt.ext_addr_match_value[2:0];
      end else begin
        st_nxt.out_xaddr[15:16-XADDR_W] = st_nxt.ext_addr_match_value;
      end
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.master_irq_en <= mscm_pkg::MASTER_IRQ_EN_RESET;
      st_r.lock_irq_en <= mscm_pkg::LOCK_IRQ_EN_RESET;
      st_r.maint <= mscm_pkg::MAINT_RESET;
      st_r.ext_addr_match_value <= XADDR_W'(mscm_pkg::XAD_RESET);
      st_r.ext_addr_mask_value <= XADDR_W'(mscm_pkg::XAM_RESET);
      st_r.tx_oe <= 2'h3;
      st_r.irq_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign awready = st_r.awready;
  assign wready = st_r.wready;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign arready = st_r.arready;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;
  assign irq_out_n = st_r.irq_n;
  assign irq_out_n_oe = st_r.irq_oe;
  assign link1_tx_pair = st_r.tx_pair[0];
  assign link2_tx_pair = st_r.tx_pair[1];
  assign link1_tx_pair_oe = st_r.tx_oe[0];
  assign link2_tx_pair_oe = st_r.tx_oe[1];
  assign rx_clk_from_tx = st_r.rx_clk_tx;
  assign rx_data_to_core = st_r.rx_data;
  assign send_defect_code = st_r.defect;
  assign cell_accept = st_r.accept;
  assign out_prepend_xaddr = st_r.out_xaddr;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  lock_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lock_change |=> st_r.lock_chg)
    else $error("lock change did not set its flag");
  code_summary_a: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready && araddr[7:2] == 6'h03 |=>
      rdata[1] == $past(|code_status_pending))
    else $error("code summary read wrong");
  serial_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready && araddr[7:2] == 6'h03 && !serial_rx_pending
      |=> !st_r.serial_rx)
    else $error("serial summary not cleared by read");
  ref_activity_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ref_rise |=> st_r.activity[2])
    else $error("reference activity not set");
  out_activity_a: assert property (@(posedge aclk) disable iff (!aresetn)
    out_rise ##1 !(arvalid && arready && araddr[7:2] == 6'h04)
      |=> st_r.activity[1])
    else $error("output activity lost before a read");
  irq_float_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !st_r.master_irq_en |-> !irq_out_n_oe)
    else $error("interrupt driven while master enable low");
  tx_float_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r.maint[mscm_pkg::MAINT_TX_FLOAT] |-> !link1_tx_pair_oe)
    else $error("link 1 driven while float bit set");
  defect_send_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) && !st_r.maint[6] && !$past(st_r.maint[6]) &&
      $past(link_los[0])
      |-> send_defect_code[0])
    else $error("defect codeword not sent on loss of signal");
  addr_accept_a: assert property (@(posedge aclk) disable iff (!aresetn)
    prepend_xaddr_valid && in_port_bus_master_sel |=> !cell_accept)
    else $error("cell accepted while input port is master");
  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r.aw_hold && st_r.w_hold && !bvalid |=> bvalid)
    else $error("write response missing");

endmodule : mscm_bank
`default_nettype wire

// ---- hw/mscm_pkg.sv ----
// mscm_pkg: register map, field positions and counts of the link maintenance bank
package mscm_pkg;

  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_MASTER_CFG = 8'h01;
  localparam logic [7:0] IDX_MISC_IRQ = 8'h03;
  localparam logic [7:0] IDX_CLK_MON = 8'h04;
  localparam logic [7:0] IDX_LINK_MAINT = 8'h05;
  localparam logic [7:0] IDX_XAD_LOW = 8'h06;
  localparam logic [7:0] IDX_XAD_HIGH = 8'h07;
  localparam logic [7:0] IDX_XAM_LOW = 8'h08;
  localparam logic [7:0] IDX_XAM_HIGH = 8'h09;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CFG_MASTER_IRQ_EN = 2;
  localparam int MISC_REF_LOCK_CHG = 0;
  localparam int MISC_CODE_STATUS = 1;
  localparam int MISC_SERIAL_RX = 2;
  localparam int MISC_EXTRACT_FIFO = 3;
  localparam int CLK_IN_ACT = 0;
  localparam int CLK_OUT_ACT = 1;
  localparam int CLK_REF_ACT = 2;
  localparam int CLK_UNLOCKED = 3;
  localparam int CLK_LOCK_IRQ_EN = 4;
  localparam int MAINT_DIAG_LOOP = 0;
  localparam int MAINT_METAL_LOOP = 2;
  localparam int MAINT_TX_FLOAT = 4;
  localparam int MAINT_DEFECT_OFF = 6;
  localparam int XAD_HIGH_BITS = 3;

  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [7:0] MAINT_RESET = 8'h00;
  localparam logic [7:0] XAD_RESET = 8'h00;
  localparam logic [7:0] XAM_RESET = 8'h00;
  localparam logic MASTER_IRQ_EN_RESET = 1'b0;
  localparam logic LOCK_IRQ_EN_RESET = 1'b0;
  localparam int SERIAL_CLK_DIV = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : mscm_pkg

// ---- hw/mscm_rise_detect.sv ----
// mscm_rise_detect: rising-transition detector for a sampled clock or level
`timescale 1ns/1ps
`default_nettype none
module mscm_rise_detect (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // watched level and its transitions
  input wire logic level_in,
  output logic rise_pulse,
  output logic change_pulse
);

  typedef struct packed {
    logic prev_r;
  } mscm_rise_state_t;

  mscm_rise_state_t st_r;
  mscm_rise_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.prev_r = level_in;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // the first sample after reset compares against a low history
  assign rise_pulse = level_in & ~st_r.prev_r;
  assign change_pulse = level_in ^ st_r.prev_r;

  rise_one_cycle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rise_pulse |=> !rise_pulse)
    else $error("rise pulse lasted more than one cycle");

endmodule : mscm_rise_detect
`default_nettype wire

// ---- dv/mscm_tb.sv ----
// testbench: self-checking bench for the link maintenance register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF, mon_clk = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic sel_bus = 1'b1, unlocked = 1'b0, srx = 1'b0;
  logic [1:0] code_p = 2'h0, fifo_p = 2'h0, los = 2'h3, lcd = 2'h0;
  logic [1:0] rloop = 2'h0, txd = 2'h2, slc = 2'h1, rec = 2'h1;
  logic o8 = 1'b1, in_m = 1'b0, out_m = 1'b0;
  logic [10:0] xaddr = 11'h000;
  wire logic awready, wready, bvalid, arready, rvalid, irq_n, irq_oe;
  wire logic tx1, tx1_oe, tx2, tx2_oe, accept;
  wire logic [1:0] bresp, rresp, rx_clk, rx_core, defect;
  wire logic [31:0] rdata;
  wire logic [15:0] oxaddr;
  wire logic irq_wire;
  int err_count = 0, comparisons = 0, cycles = 0;

  // open-drain interrupt pin with its pull-up
  assign irq_wire = irq_oe ? irq_n : 1'b1;

  mscm_bank DUT (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .bus_input_clock(mon_clk[0]), .bus_output_clock(mon_clk[1]),
    .reference_clock_in(mon_clk[2]), .hs_link_clock(mon_clk[3]),
    .bus_interface_select(sel_bus), .ref_unlocked_in(unlocked),
    .code_status_pending(code_p), .serial_rx_pending(srx),
    .extract_fifo_pending(fifo_p), .irq_out_n(irq_n), .irq_out_n_oe(irq_oe),
    .link_los(los), .link_lcd(lcd), .remote_loop_req(rloop),
    .link_tx_data(txd), .link_rx_sliced(slc), .link_rx_recovered(rec),
    .link1_tx_pair(tx1), .link1_tx_pair_oe(tx1_oe), .link2_tx_pair(tx2),
    .link2_tx_pair_oe(tx2_oe), .rx_clk_from_tx(rx_clk),
    .rx_data_to_core(rx_core), .send_defect_code(defect),
    .in_port_bus_master_sel(in_m), .ext_addr_protocol_sel(1'b1),
    .prepend_xaddr_in(xaddr), .prepend_xaddr_valid(1'b1),
    .cell_accept(accept), .out_port_bus_master_sel(out_m),
    .out_bus8_sel(o8), .out_prepend_in(16'hFFFF),
    .out_prepend_xaddr(oxaddr)
  );

  always #50 aclk = ~aclk;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s saw %h expected %h", $time, what, seen,
               exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF,
                    input logic [1:0] er = mscm_pkg::RESP_OKAY);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er, "write response");
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er = mscm_pkg::RESP_OKAY);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, exp, "read data");
    chk(rresp, er, "read response");
  endtask : rd

  // registered outputs show one edge after the inputs are sampled
  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask : settle

  // monitored clocks must stay slower than half of aclk to be seen
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      @(posedge aclk);
      mon_clk[i] <= 1'b1;
      repeat (2) @(posedge aclk);
      mon_clk[i] <= 1'b0;
      @(posedge aclk);
    end
  endtask : pulse

  task automatic chk_link(input logic [9:0] exp);
    settle();
    chk({rx_clk, rx_core, tx1, tx1_oe, tx2, tx2_oe, defect}, exp, "links");
  endtask : chk_link

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h3C, 32'h0, mscm_pkg::RESP_SLVERR);
    wr(8'h3C, 32'hFF, 4'hF, mscm_pkg::RESP_SLVERR);
    wr(8'h0C, 32'hFF);
  endtask : t_regs

  task automatic t_links;
    wr(8'h14, 32'hFFFF_FF55);
    chk_link(10'b01_00_1011_10);
    rd(8'h14, 32'h55);
    wr(8'h14, 32'hAA, 4'hE);
    rd(8'h14, 32'h55);
    wr(8'h14, 32'hAA);
    chk_link(10'b10_11_0100_01);
    @(posedge aclk);
    los <= 2'h0;
    lcd <= 2'h2;
    rloop <= 2'h2;
    wr(8'h14, 32'h0); // clear all maintenance bits; link 2 loops on remote request
    chk_link(10'b00_01_0101_10);
  endtask : t_links

  task automatic t_status;
    @(posedge aclk);
    code_p <= 2'h2;
    fifo_p <= 2'h1;
    settle();
    rd(8'h0C, 32'h0A);
    rd(8'h0C, 32'h0A);
    code_p <= 2'h0;
    fifo_p <= 2'h0;
    srx <= 1'b1;
    @(posedge aclk);
    srx <= 1'b0;
    settle();
    rd(8'h0C, 32'h04);
    rd(8'h0C, 32'h00);
    wr(8'h10, 32'h10);
    @(posedge aclk);
    unlocked <= 1'b1;
    repeat (4) @(posedge aclk);
    #1;
    chk(irq_wire, 1'b1, "irq pin");
    rd(8'h0C, 32'h01);
    rd(8'h0C, 32'h00);
    wr(8'h04, 32'hFF);
    rd(8'h04, 32'h04);
    @(posedge aclk);
    unlocked <= 1'b0;
    repeat (4) @(posedge aclk);
    #1;
    chk(irq_wire, 1'b0, "irq pin");
    rd(8'h0C, 32'h01);
    settle();
    chk(irq_wire, 1'b1, "irq pin");
  endtask : t_status

  task automatic t_clkmon;
    rd(8'h10, 32'h10);
    for (int i = 0; i < 3; i++) begin
      pulse(i, 1);
      rd(8'h10, 32'h10 | (32'h1 << i));
      rd(8'h10, 32'h10);
    end
    sel_bus <= 1'b0;
    pulse(0, 2);
    rd(8'h10, 32'h10);
    pulse(3, 12);
    rd(8'h10, 32'h11);
    unlocked <= 1'b1;
    settle();
    rd(8'h10, 32'h18);
  endtask : t_clkmon

  task automatic t_xaddr;
    wr(8'h18, 32'h5A);
    wr(8'h1C, 32'hFD);
    rd(8'h1C, 32'h05);
    xaddr <= 11'h7FF;
    settle();
    chk(accept, 1'b1, "accept");
    wr(8'h20, 32'hF0);
    wr(8'h24, 32'h07);
    xaddr <= 11'h553;
    settle();
    chk(accept, 1'b1, "accept");
    @(posedge aclk);
    xaddr <= 11'h45A;
    settle();
    chk(accept, 1'b0, "accept");
    chk(oxaddr, 16'hFF5F, "prepend");
    @(posedge aclk);
    o8 <= 1'b0;
    xaddr <= 11'h553;
    in_m <= 1'b1;
    settle();
    chk(accept, 1'b0, "accept");
    chk(oxaddr, 16'hAB5F, "prepend");
    @(posedge aclk);
    in_m <= 1'b0;
    out_m <= 1'b1;
    settle();
    chk(accept, 1'b1, "accept");
    chk(oxaddr, 16'hFFFF, "prepend");
  endtask : t_xaddr

  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // the whole run needs a few hundred cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_links();
    t_status();
    t_clkmon();
    t_xaddr();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
